// file: core/io_pm_pkg.sv
/*
 * Shared constants and types of the IO and power management register:
 * register indices, field positions, reset value, regulator codes, modes,
 * the regulator tracking states and the state struct of the top module.
 * Assumes a single 125 MHz clock and AHB-Lite with 32-bit data.
 */
package io_pm_pkg;

    // ========================================================================
    // register map
    // printed offsets are not word aligned: they are indices, byte address x4
    localparam logic [7:0]  IDX_BASE     = 8'h39;
    localparam logic [7:0]  IDX_SET      = 8'h3A;
    localparam logic [7:0]  IDX_CLR      = 8'h3B;
    localparam logic [7:0]  IDX_NONE     = 8'h00;
    localparam logic [7:0]  RESET_VAL    = 8'h04;
    localparam logic [7:0]  WR_MASK      = 8'hFE;
    localparam int          BIT_RSVD     = 0;
    localparam int          BIT_SWAP     = 1;
    localparam int          UART_LVL_LO  = 2;
    localparam int          POS_PULL     = 4;
    localparam int          NEG_PULL     = 5;
    localparam int          USB_LVL_LO   = 6;

    // ========================================================================
    // regulator output codes
    localparam logic [1:0]  LVL_3V3      = 2'h0;
    localparam logic [1:0]  LVL_3V0      = 2'h1;
    localparam logic [1:0]  LVL_2V75     = 2'h2;
    localparam logic [1:0]  LVL_2V5      = 2'h3;

    // ========================================================================
    // bus constants
    localparam logic [1:0]  HTRANS_IDLE  = 2'h0;
    localparam logic [1:0]  HTRANS_NSEQ  = 2'h2;
    localparam logic        HRESP_OKAY   = 1'h0;

    // ========================================================================
    // modes and states
    typedef enum logic [4:0] {
        MODE_SYNC   = 5'h01,
        MODE_SERIAL = 5'h02,
        MODE_LOWPWR = 5'h04,
        MODE_UART   = 5'h08,
        MODE_AUDIO  = 5'h10
    } phy_mode_e;

    typedef enum logic [3:0] {
        RS_USB       = 4'h1,
        RS_UART_WAIT = 4'h2,
        RS_UART      = 4'h4,
        RS_AUDIO     = 4'h8
    } reg_state_e;

    typedef struct packed {
        logic posOut;
        logic posOe;
        logic negOut;
        logic negOe;
    } pin_drive_s;

    typedef struct packed {
        logic pos;
        logic neg;
    } line_pair_s;

    typedef struct packed {
        logic [7:0]  regQ;
        logic        phValid;
        logic        phWrite;
        logic [7:0]  phIdx;
        logic [31:0] rdata;
        reg_state_e  regState;
        logic [1:0]  level;
        pin_drive_s  pins;
        line_pair_s  rx;
        logic        posPull;
        logic        negPull;
    } io_pm_state_s;

    localparam io_pm_state_s STATE_RESET = '{
        regQ: RESET_VAL, phValid: 1'b0, phWrite: 1'b0, phIdx: IDX_NONE,
        rdata: 32'h0, regState: RS_USB, level: LVL_3V3, pins: '0, rx: '0,
        posPull: 1'b0, negPull: 1'b0};

    // byte address of a register index
    function automatic logic [31:0] regAddr(input logic [7:0] idx);
        regAddr = {22'h0, idx, 2'h0};
    endfunction

endpackage

// file: core/line_router.sv
/*
 * Routing of the two data-line pins between the USB transceiver, the UART
 * and the audio path, with the optional exchange of the two lines.
 * Assumes the caller registers the results; purely combinational.
 */
module line_router
    import io_pm_pkg::*;
(
    input  wire logic       swap,
    input  wire logic       uartMode,
    input  wire logic       audioMode,
    input  wire pin_drive_s usbDrv,
    input  wire pin_drive_s uartDrv,
    input  wire pin_drive_s audioDrv,
    input  wire line_pair_s pinIn,
    output pin_drive_s      pinDrv,
    output line_pair_s      rxLines
);

    pin_drive_s src;

    always_comb begin
        src = uartMode ? uartDrv : usbDrv;
        if (audioMode) begin
            pinDrv = audioDrv;
        end else if (swap) begin
            pinDrv = '{posOut: src.negOut, posOe: src.negOe,
                       negOut: src.posOut, negOe: src.posOe};
        end else begin
            pinDrv = src;
        end
        if (swap && !audioMode) begin
            rxLines = '{pos: pinIn.neg, neg: pinIn.pos};
        end else begin
            rxLines = pinIn;
        end
    end

endmodule

// file: core/regulator_level_mux.sv
/*
 * Selects the regulator output code from the tracking state.
 * Assumes the caller supplies the held code for the waiting state.
 */
module regulator_level_mux
    import io_pm_pkg::*;
(
    input  wire reg_state_e state,
    input  wire logic [1:0] usbLevel,
    input  wire logic [1:0] uartLevel,
    input  wire logic [1:0] heldLevel,
    output logic [1:0]      level
);

    always_comb begin
        case (state)
            RS_USB:       level = usbLevel;
            RS_UART:      level = uartLevel;
            RS_UART_WAIT: level = heldLevel;
            RS_AUDIO:     level = LVL_3V3;
            default:      level = LVL_3V3;
        endcase
    end

endmodule

// file: core/usb_io_power_control_reg.sv
/*
 * IO and power management register of the transceiver, reached over an
 * AHB-Lite slave, driving the data-line routing, the charger pull-ups and
 * the regulator output code.
 * Assumes it is the only slave on the bus, mode and driver inputs are
 * synchronous to ref_clk, and the analog parts sit outside.
 */
// How it works
// - read all three, write base, set, clear
// - swap bit exchanges the two data pins
// - swap also applies to UART routing
// - audio pins ignore the swap bit
// - UART level field, reset 01, four codes
// - UART level applied once transmit enable seen
// - audio mode holds regulator at 3.3V
// - bits 4 and 5 enable line pull-ups
// - UART mode forces both pull-ups on
// - USB level field used in USB modes
module usb_io_power_control_reg
    import io_pm_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        rst_b,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    input  wire phy_mode_e   phyMode,
    input  wire logic        uartTransmitEnable,
    input  wire pin_drive_s  usbDrv,
    input  wire pin_drive_s  uartDrv,
    input  wire pin_drive_s  audioDrv,
    input  wire line_pair_s  pinIn,
    output pin_drive_s       pinDrv,
    output line_pair_s       rxLines,
    output logic             posLinePullupEnable,
    output logic             negLinePullupEnable,
    output logic [1:0]       regulatedSupplyLevel
);

    // ========================================================================
    // state
    io_pm_state_s st;
    io_pm_state_s nx;
    logic [7:0]   wrByte;
    logic [7:0]   hitIdx;
    logic         take;
    logic         usbMode;
    logic         uartMode;
    logic         audioMode;
    logic [1:0]   levelD;
    pin_drive_s   pinsD;
    line_pair_s   rxD;

    assign usbMode   = (phyMode == MODE_SYNC) || (phyMode == MODE_SERIAL)
                    || (phyMode == MODE_LOWPWR);
    assign uartMode  = (phyMode == MODE_UART);
    assign audioMode = (phyMode == MODE_AUDIO);

    // ========================================================================
    // helpers
    regulator_level_mux u_level (
        .state     (nx.regState),
        .usbLevel  (nx.regQ[USB_LVL_LO +: 2]),
        .uartLevel (nx.regQ[UART_LVL_LO +: 2]),
        .heldLevel (st.level),
        .level     (levelD)
    );

    // swap is taken from the stored bit so a write lands on the pins one
    // cycle after it lands in the register
    line_router u_router (
        .swap      (st.regQ[BIT_SWAP]),
        .uartMode  (uartMode),
        .audioMode (audioMode),
        .usbDrv    (usbDrv),
        .uartDrv   (uartDrv),
        .audioDrv  (audioDrv),
        .pinIn     (pinIn),
        .pinDrv    (pinsD),
        .rxLines   (rxD)
    );

    // ========================================================================
    // next state
    always_comb begin
        nx     = st;
        wrByte = hwdata[7:0] & WR_MASK;
        take   = hsel && hready && htrans[1];
        if (haddr == regAddr(IDX_BASE)) begin
            hitIdx = IDX_BASE;
        end else if (haddr == regAddr(IDX_SET)) begin
            hitIdx = IDX_SET;
        end else if (haddr == regAddr(IDX_CLR)) begin
            hitIdx = IDX_CLR;
        end else begin
            hitIdx = IDX_NONE;
        end

        // data phase of a write
        if (st.phValid && st.phWrite) begin
            case (st.phIdx)
                IDX_BASE: nx.regQ = wrByte;
                IDX_SET:  nx.regQ = st.regQ | wrByte;
                IDX_CLR:  nx.regQ = st.regQ & ~wrByte;
                default:  nx.regQ = st.regQ;
            endcase
        end
        nx.regQ[BIT_RSVD] = 1'b0;

        // address phase; read data reflect a write in its data phase
        nx.phValid = take;
        nx.phWrite = hwrite;
        nx.phIdx   = take ? hitIdx : IDX_NONE;
        if (take && !hwrite && hitIdx != IDX_NONE) begin
            nx.rdata = {24'h0, nx.regQ};
        end else begin
            nx.rdata = 32'h0;
        end

        // regulator tracking; a mode outside the list counts as USB
        if (audioMode) begin
            nx.regState = RS_AUDIO;
        end else if (uartMode) begin
            case (st.regState)
                RS_UART:      nx.regState = RS_UART;
                RS_USB,
                RS_UART_WAIT,
                RS_AUDIO:     nx.regState = uartTransmitEnable ? RS_UART
                                                               : RS_UART_WAIT;
                default:      nx.regState = RS_UART_WAIT;
            endcase
        end else begin
            nx.regState = RS_USB;
        end
        nx.level = levelD;

        // pins and pull-ups
        nx.pins    = pinsD;
        nx.rx      = rxD;
        nx.posPull = nx.regQ[POS_PULL] | uartMode;
        nx.negPull = nx.regQ[NEG_PULL] | uartMode;
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            st <= STATE_RESET;
        end else begin
            st <= nx;
        end
    end

    // ========================================================================
    // outputs
    // zero wait states: the register is always ready
    assign hreadyout            = 1'b1;
    assign hresp                = HRESP_OKAY;
    assign hrdata               = st.rdata;
    assign pinDrv               = st.pins;
    assign rxLines              = st.rx;
    assign posLinePullupEnable  = st.posPull;
    assign negLinePullupEnable  = st.negPull;
    assign regulatedSupplyLevel = st.level;

    // ========================================================================
    // checks
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_b);

    sequence s_wr_base;
        st.phValid && st.phWrite && st.phIdx == IDX_BASE;
    endsequence

    sequence s_wr_set;
        st.phValid && st.phWrite && st.phIdx == IDX_SET;
    endsequence

    sequence s_wr_clr;
        st.phValid && st.phWrite && st.phIdx == IDX_CLR;
    endsequence

    sequence s_rd_hit;
        take && !hwrite && hitIdx != IDX_NONE;
    endsequence

    sequence s_uart_enter;
        uartMode && uartTransmitEnable;
    endsequence

    property p_load;
        s_wr_base |=> st.regQ == $past(wrByte);
    endproperty
    a_load: assert property (p_load)
        else $error("base write did not load the register");

    property p_set;
        s_wr_set |=> st.regQ == ($past(st.regQ) | $past(wrByte));
    endproperty
    a_set: assert property (p_set)
        else $error("set alias did not set the written ones");

    property p_clr;
        s_wr_clr |=> st.regQ == ($past(st.regQ) & ~$past(wrByte));
    endproperty
    a_clr: assert property (p_clr)
        else $error("clear alias did not clear the written ones");

    property p_read;
        s_rd_hit |=> hrdata == {24'h0, st.regQ};
    endproperty
    a_read: assert property (p_read)
        else $error("read data differ from the register");

    property p_reserved;
        st.regQ[BIT_RSVD] == 1'b0 && hrdata[BIT_RSVD] == 1'b0;
    endproperty
    a_reserved: assert property (p_reserved)
        else $error("reserved bit is not zero");

    property p_swap_usb;
        usbMode && st.regQ[BIT_SWAP]
        |=> pinDrv.posOut == $past(usbDrv.negOut)
            && pinDrv.negOe == $past(usbDrv.posOe);
    endproperty
    a_swap_usb: assert property (p_swap_usb)
        else $error("usb lines not exchanged while swap is set");

    property p_swap_uart;
        uartMode && st.regQ[BIT_SWAP]
        |=> pinDrv.posOut == $past(uartDrv.negOut)
            && pinDrv.negOut == $past(uartDrv.posOut);
    endproperty
    a_swap_uart: assert property (p_swap_uart)
        else $error("uart lines not exchanged while swap is set");

    property p_audio_pins;
        audioMode |=> pinDrv == $past(audioDrv);
    endproperty
    a_audio_pins: assert property (p_audio_pins)
        else $error("audio pins affected by swap");

    property p_audio_level;
        audioMode |=> regulatedSupplyLevel == LVL_3V3;
    endproperty
    a_audio_level: assert property (p_audio_level)
        else $error("regulator not at 3.3V in audio mode");

    property p_uart_hold;
        uartMode && !uartTransmitEnable && st.regState != RS_UART
        |=> $stable(regulatedSupplyLevel);
    endproperty
    a_uart_hold: assert property (p_uart_hold)
        else $error("regulator moved before transmit enable");

    property p_uart_level;
        s_uart_enter ##1 uartMode
        |=> regulatedSupplyLevel == st.regQ[UART_LVL_LO +: 2];
    endproperty
    a_uart_level: assert property (p_uart_level)
        else $error("uart level not applied after transmit enable");

    property p_usb_level;
        usbMode |=> regulatedSupplyLevel == st.regQ[USB_LVL_LO +: 2];
    endproperty
    a_usb_level: assert property (p_usb_level)
        else $error("usb level not applied in usb modes");

    property p_pullups;
        1'b1 |=> posLinePullupEnable == (st.regQ[POS_PULL] || $past(uartMode))
              && negLinePullupEnable == (st.regQ[NEG_PULL] || $past(uartMode));
    endproperty
    a_pullups: assert property (p_pullups)
        else $error("pull-up enables wrong");

    property p_uart_pullups;
        uartMode |=> posLinePullupEnable && negLinePullupEnable;
    endproperty
    a_uart_pullups: assert property (p_uart_pullups)
        else $error("uart mode did not force both pull-ups on");

    property p_rx_swap;
        (usbMode || uartMode) && st.regQ[BIT_SWAP]
        |=> rxLines.pos == $past(pinIn.neg) && rxLines.neg == $past(pinIn.pos);
    endproperty
    a_rx_swap: assert property (p_rx_swap)
        else $error("received lines not exchanged while swap is set");

    property p_rx_audio;
        audioMode |=> rxLines == $past(pinIn);
    endproperty
    a_rx_audio: assert property (p_rx_audio)
        else $error("audio receive path affected by swap");

    property p_usb_straight;
        usbMode && !st.regQ[BIT_SWAP] |=> pinDrv == $past(usbDrv);
    endproperty
    a_usb_straight: assert property (p_usb_straight)
        else $error("usb lines exchanged while swap is clear");

    property p_unmapped_read;
        take && !hwrite && hitIdx == IDX_NONE |=> hrdata == 32'h0;
    endproperty
    a_unmapped_read: assert property (p_unmapped_read)
        else $error("read outside the register returned data");

endmodule

// file: testbench/link_master.sv
/*
 * Link-side bus master model: single-word AHB-Lite transfers to the
 * IO and power management register, one task per transfer.
 * Assumes the caller enters a task just after a rising edge of ref_clk
 * and that hready is the only slave's hreadyout.
 */
module link_master
    import io_pm_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        hready,
    input  wire logic [31:0] hrdata,
    output logic             hsel,
    output logic [31:0]      haddr,
    output logic [1:0]       htrans,
    output logic             hwrite,
    output logic [2:0]       hsize,
    output logic [31:0]      hwdata
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        hsel   = 1'b0;
        haddr  = 32'h0;
        htrans = HTRANS_IDLE;
        hwrite = 1'b0;
        hsize  = 3'h2;
        hwdata = 32'h0;
    end

    // ========================================================================
    // transfers
    // no fixed latency is assumed: the tb's cycle ceiling ends a hang
    task automatic waitReady();
        do @(posedge ref_clk); while (hready !== 1'b1);
    endtask

    // index times four is the byte address of a register
    task automatic access(input logic wr, input logic [7:0] idx, input logic [31:0] wdata,
                          output logic [31:0] rdata);
        hsel   <= 1'b1;
        haddr  <= {22'h0, idx, 2'h0};
        htrans <= HTRANS_NSEQ;
        hwrite <= wr;
        waitReady();
        htrans <= HTRANS_IDLE;
        hwdata <= wdata;
        waitReady();
        rdata = hrdata;
    endtask

    // bus released: stale address and data are inverted so nothing leans on them
    task automatic park();
        haddr  <= ~haddr;
        hwdata <= ~hwdata;
        @(posedge ref_clk);
    endtask
endmodule

// file: testbench/tb.sv
/*
 * Self-checking bench of the IO and power management register: register
 * traffic through the link model, pin routing, pull-ups and regulator code.
 * Assumes the design package and the link_master model are compiled first.
 */
module tb
    import io_pm_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic        ref_clk, rst_b, hsel, hwrite, hreadyout, hresp, txEn, posPull, negPull;
    logic [31:0] haddr, hwdata, hrdata, rdVal;
    logic [1:0]  htrans, level;
    logic [2:0]  hsize;
    logic [7:0]  regModel, idx, wd;
    logic        sw, uartOn;
    phy_mode_e   phyMode;
    pin_drive_s  usbDrv, uartDrv, audioDrv, pinDrv;
    line_pair_s  pinIn, rxLines;
    int          seed, nMismatch, numChecks, cycles;
    phy_mode_e   modes[5] = '{MODE_SYNC, MODE_SERIAL, MODE_LOWPWR, MODE_UART, MODE_AUDIO};
    logic [7:0]  idxTab[6] = '{IDX_BASE, IDX_SET, IDX_CLR, 8'h38, 8'h3C, 8'h00};

    always #4 ref_clk = ~ref_clk;

    usb_io_power_control_reg DUT (.ref_clk(ref_clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .phyMode(phyMode),
        .uartTransmitEnable(txEn), .usbDrv(usbDrv), .uartDrv(uartDrv), .audioDrv(audioDrv),
        .pinIn(pinIn), .pinDrv(pinDrv), .rxLines(rxLines), .posLinePullupEnable(posPull),
        .negLinePullupEnable(negPull), .regulatedSupplyLevel(level));

    link_master link (.ref_clk(ref_clk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));

    // ========================================================================
    // expectations
    function automatic logic [7:0] nextReg(input logic [7:0] cur, input logic [7:0] i,
                                           input logic [7:0] d);
        case (i)
            IDX_BASE: return d & WR_MASK;
            IDX_SET:  return cur | (d & WR_MASK);
            IDX_CLR:  return cur & ~(d & WR_MASK);
            default:  return cur;
        endcase
    endfunction

    function automatic pin_drive_s expPins(input phy_mode_e m, input logic sw);
        pin_drive_s d;
        d = (m == MODE_UART) ? uartDrv : (m == MODE_AUDIO) ? audioDrv : usbDrv;
        if (sw && m != MODE_AUDIO) return '{posOut: d.negOut, posOe: d.negOe,
                                            negOut: d.posOut, negOe: d.posOe};
        return d;
    endfunction

    function automatic line_pair_s expRx(input phy_mode_e m, input logic sw);
        if (sw && m != MODE_AUDIO) return '{pos: pinIn.neg, neg: pinIn.pos};
        return pinIn;
    endfunction

    // ========================================================================
    // helpers
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        numChecks++;
        if (seen !== exp) begin
            nMismatch++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", numChecks, nMismatch);
        if (nMismatch == 0 && numChecks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // reset also reloads the register model; the caller leaves UART mode by driving phyMode
    task automatic doReset();
        rst_b <= 1'b0;
        repeat (10) @(posedge ref_clk);
        rst_b <= 1'b1;
        regModel = RESET_VAL;
        @(posedge ref_clk);
    endtask

    task automatic wr(input logic [7:0] i, input logic [7:0] d);
        link.access(1'b1, i, {$random(seed)} & 32'hFFFFFF00 | d, rdVal);
        regModel = nextReg(regModel, i, d);
    endtask

    task automatic rdChk(input logic [7:0] i);
        logic [31:0] want;
        want = (i >= IDX_BASE && i <= IDX_CLR) ? {24'h0, regModel} : 32'h0;
        link.access(1'b0, i, 32'h0, rdVal);
        check("read data", rdVal, want);
    endtask

    // outputs lag inputs by a cycle and pins lag the register by one more
    task automatic settle();
        repeat (3) @(posedge ref_clk);
        #1;
    endtask

    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 8000) begin
            nMismatch++;
            results();
        end
    end

    // ========================================================================
    // main sequence
    initial begin
        seed = 33;
        ref_clk = 1'b0;
        rst_b = 1'b0;
        nMismatch = 0;
        numChecks = 0;
        cycles = 0;
        phyMode = MODE_SYNC;
        txEn = 1'b0;
        usbDrv = '0;
        uartDrv = '0;
        audioDrv = '0;
        pinIn = '0;
        doReset();
        for (int k = 0; k < 3; k++) rdChk(idxTab[k]);
        check("hresp", {31'h0, hresp}, {31'h0, HRESP_OKAY});
        check("hreadyout", {31'h0, hreadyout}, 32'h1);
        $display("test reset values done");

        repeat (60) begin
            idx = idxTab[{$random(seed)} % 6];
            wd = 8'($random(seed));
            wr(idx, wd);
            rdChk(idxTab[{$random(seed)} % 6]);
        end
        for (int k = 0; k < 3; k++) wr(idxTab[k], 8'hFF);
        rdChk(IDX_BASE);
        link.park();
        $display("test register traffic done");

        for (int m = 0; m < 5; m++) begin
            for (int s = 0; s < 2; s++) begin
                wr(IDX_BASE, {8'($random(seed))} & 8'hFD | {6'h0, s[0], 1'b0});
                phyMode <= modes[m];
                usbDrv <= pin_drive_s'(4'($random(seed)));
                uartDrv <= pin_drive_s'(4'($random(seed)));
                audioDrv <= pin_drive_s'(4'($random(seed)));
                pinIn <= line_pair_s'(2'($random(seed)));
                settle();
                sw = regModel[BIT_SWAP];
                uartOn = (modes[m] == MODE_UART);
                check("pin drive", 32'(pinDrv), 32'(expPins(modes[m], sw)));
                check("rx lines", 32'(rxLines), 32'(expRx(modes[m], sw)));
                check("pos pullup", 32'(posPull), 32'(regModel[POS_PULL] | uartOn));
                check("neg pullup", 32'(negPull), 32'(regModel[NEG_PULL] | uartOn));
                if (m < 3) check("usb level", 32'(level), 32'(regModel[7:6]));
                @(posedge ref_clk);
            end
        end
        $display("test routing and pullups done");

        phyMode <= MODE_SYNC;
        wr(IDX_BASE, 8'h8C);
        settle();
        check("level usb", 32'(level), 32'(LVL_2V75));
        @(posedge ref_clk);
        phyMode <= MODE_UART;
        settle();
        check("level held", 32'(level), 32'(LVL_2V75));
        @(posedge ref_clk);
        txEn <= 1'b1;
        settle();
        check("level uart", 32'(level), 32'(LVL_2V5));
        @(posedge ref_clk);
        phyMode <= MODE_AUDIO;
        settle();
        check("level audio", 32'(level), 32'(LVL_3V3));
        @(posedge ref_clk);
        phyMode <= MODE_UART;
        txEn <= 1'b0;
        settle();
        check("level from audio", 32'(level), 32'(LVL_3V3));
        @(posedge ref_clk);
        txEn <= 1'b1;
        settle();
        check("level uart again", 32'(level), 32'(LVL_2V5));
        @(posedge ref_clk);
        phyMode <= MODE_SYNC;
        doReset();
        #1;
        check("level after reset", 32'(level), 32'(LVL_3V3));
        @(posedge ref_clk);
        rdChk(IDX_CLR);
        $display("test regulator level done");
        results();
    end
endmodule
